// File: hw/irq_ctrl_defines.vh
// constants of the interrupt register bank: offsets, field layout, alias codes
// included by every design file of the block; definitions only
`ifndef IRQ_CTRL_DEFINES_VH
`define IRQ_CTRL_DEFINES_VH

// word offsets within the bank (byte addresses)
`define OFS_CONTROL      16'h1000
`define OFS_STATUS       16'h1010
`define OFS_TIMER        16'h1020
`define OFS_FLAGS0       16'h1030
`define OFS_FLAGS1       16'h1040
`define OFS_ENABLES0     16'h1060
`define OFS_ENABLES1     16'h1070
`define OFS_PRIO_BASE    16'h1090
`define OFS_PRIO_STRIDE  16'h0010
`define OFS_EVT_STATUS   16'h1100
`define OFS_EVT_MASK     16'h1110
`define NUM_PRIO_GROUPS  7

// companion alias selected by address bits 3:2
`define ALIAS_LSB        2
`define ALIAS_MASK       16'h000C
`define OP_WRITE         2'h0
`define OP_CLEAR         2'h1
`define OP_SET           2'h2
`define OP_INVERT        2'h3

// control word fields
`define CTL_POL_LSB      0
`define CTL_POL_W        5
`define CTL_TPC_LSB      8
`define CTL_MULTI_VECTOR_SELECT_BIT     12
`define CTL_IMPL         32'h0000171F

// status word fields
`define STAT_LVL_LSB     8
`define STAT_VEC_LSB     0

// priority slot: level above sublevel, top three bits unimplemented
`define SLOT_W           8
`define SLOT_SUB_LSB     0
`define SLOT_LVL_LSB     2
`define PRIO_IMPL        32'h1F1F1F1F

// external input flag positions in flag word 0
`define EXT0_BIT         3
`define EXT1_BIT         8
`define EXT2_BIT         13
`define EXT3_BIT         18
`define EXT4_BIT         23

// usb flag/enable position in word 1
`define USB_BIT          3

// event status bits
`define EVT_FLAG_BIT     0
`define EVT_ERR_BIT      1
`define EVT_IMPL         32'h00000003

`define ALL_ONES         32'hFFFFFFFF
`define ALL_ZERO         32'h00000000

`endif

// File: hw/alias_reg.v
// one software register with write, clear, set and invert aliases
// assumes a single-cycle write strobe; hardware set bits win over any clear
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"

module alias_reg #(
    parameter             WIDTH = 32,
    parameter [WIDTH-1:0] IMPL  = {WIDTH{1'b1}}
) (
    input  wire             clk,     // system clock
    input  wire             resetn,  // async reset, active low
    input  wire             wr_en,   // one-cycle write strobe
    input  wire [1:0]       op,      // alias operation
    input  wire [WIDTH-1:0] wdata,   // bus write data
    input  wire [WIDTH-1:0] hw_set,  // hardware set pulses
    output reg  [WIDTH-1:0] q        // register value
);

    reg [WIDTH-1:0] sw_d;
    reg [WIDTH-1:0] q_d;

    always @* begin
        case (op)
            `OP_CLEAR:  sw_d = q & ~wdata;
            `OP_SET:    sw_d = q | wdata;
            `OP_INVERT: sw_d = q ^ wdata;
            default:    sw_d = wdata;
        endcase
        q_d = ((wr_en ? sw_d : q) | hw_set) & IMPL;
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q <= {WIDTH{1'b0}};
        end else begin
            q <= q_d;
        end
    end

endmodule // alias_reg

// File: hw/priority_pick.v
// picks the pending source of highest level, then sublevel, then lowest vector
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"

module priority_pick #(
    parameter NSRC  = 64,
    parameter NSLOT = 28
) (
    input  wire [NSRC-1:0]          pending,    // flag and enable per source
    input  wire [NSLOT*`SLOT_W-1:0] slots,      // priority slots, slot 0 lowest
    output reg                      valid,      // some source requests
    output reg  [2:0]               level,      // winning level
    output reg  [5:0]               vector      // winning vector
);

    // flag bit to priority slot: two capture flags share one slot
    function integer slot_of;
        input integer i;
        integer j;
        begin
            j = i - 4;
            if (i < 4)
                slot_of = i;
            else if (i < 29)
                slot_of = 4 + 4 * (j / 5) + ((j % 5 == 0) ? 0 :
                          (j % 5 <= 2) ? 1 : (j % 5 == 3) ? 2 : 3);
            else
                slot_of = i - 5;
        end
    endfunction

    integer i;
    integer s;
    reg [4:0] key;
    reg [4:0] best;

    always @* begin
        valid  = 1'b0;
        level  = 3'h0;
        vector = 6'h00;
        best   = 5'h00;
        key    = 5'h00;
        s      = 0;
        for (i = 0; i < NSRC; i = i + 1) begin
            s = slot_of(i);
            if (s < NSLOT) begin
                key = slots[s*`SLOT_W +: 5];
            end else begin
                key = 5'h00;
            end
            // level zero keeps a source silent; strict compare keeps lowest vector
            if (pending[i] && key[4:2] != 3'h0 && key > best) begin
                best   = key;
                valid  = 1'b1;
                level  = key[4:2];
                vector = s[5:0];
            end
        end
    end

endmodule // priority_pick

// File: hw/irq_ctrl.v
// interrupt register bank with APB slave, source arbitration and latency window
// assumes peripheral requests and external inputs are synchronous to clk
//
// Contract
// - every register except status and event status has clear, set and invert companions
// - companions sit at base plus 0x4, 0x8 and 0xC
// - status word decodes only at its base address
// - unimplemented bits read zero and ignore writes
// - every register resets to all zeros
// - control bits 4..0 select edge polarity of external inputs 0..4
// - control bit 12 selects multi-vector, bits 10..8 timer threshold
// - status gives level in bits 10..8, vector in bits 5..0
// - priority words hold four slots: level above sublevel, top bits empty
// - enable bit sits at the same position as its flag
// - without usb the usb flag and enable read zero
`timescale 1ns/1ps
`include "irq_ctrl_defines.vh"

module irq_ctrl #(
    parameter       NSRC    = 64,
    parameter       NEXT    = 5,
    parameter       HAS_USB = 1
) (
    input  wire             clk,          // 25 MHz system clock
    input  wire             resetn,       // async reset, active low
    input  wire             psel,         // apb select
    input  wire             penable,      // apb access phase
    input  wire             pwrite,       // apb direction
    input  wire [15:0]      paddr,        // apb byte address
    input  wire [31:0]      pwdata,       // apb write data
    input  wire [3:0]       pstrb,        // apb byte strobes, full words only
    output wire             pready,       // apb ready, always high
    output reg  [31:0]      prdata,       // apb read data
    output wire             pslverr,      // apb error on unmapped address
    input  wire [NSRC-1:0]  periph_req,   // peripheral request pulses
    input  wire [NEXT-1:0]  ext_in,       // external interrupt inputs
    output reg              cpu_request,  // request to the core
    output reg  [2:0]       cpu_level,    // requested level to the core
    output reg  [5:0]       cpu_vector,   // vector to the core
    output wire             irq           // block event interrupt
);

    localparam NSLOT = `NUM_PRIO_GROUPS * 4;
    localparam [31:0] USB_MASK = HAS_USB ? `ALL_ONES : ~(32'h1 << `USB_BIT);

    wire        bus_acc = psel & penable;
    wire        bus_wr  = bus_acc & pwrite & (pstrb == 4'hF);
    wire [15:0] base    = paddr & ~`ALIAS_MASK;
    wire [1:0]  op      = paddr[`ALIAS_LSB +: 2];

    // address decode
    wire hit_ctl  = (base == `OFS_CONTROL);
    wire hit_stat = (paddr == `OFS_STATUS);
    wire hit_tmr  = (base == `OFS_TIMER);
    wire hit_f0   = (base == `OFS_FLAGS0);
    wire hit_f1   = (base == `OFS_FLAGS1);
    wire hit_e0   = (base == `OFS_ENABLES0);
    wire hit_e1   = (base == `OFS_ENABLES1);
    wire hit_evs  = (base == `OFS_EVT_STATUS);
    wire hit_evm  = (base == `OFS_EVT_MASK);
    wire [15:0] prio_rel = base - `OFS_PRIO_BASE;
    wire [15:0] prio_idx = prio_rel >> 4;
    wire hit_prio = (base >= `OFS_PRIO_BASE) &&
                    (prio_idx < `NUM_PRIO_GROUPS);
    wire mapped   = hit_ctl | hit_stat | hit_tmr | hit_f0 | hit_f1 | hit_e0 |
                    hit_e1 | hit_evs | hit_evm | hit_prio;

    assign pready  = 1'b1;
    assign pslverr = bus_acc & ~mapped;

    // register values
    wire [31:0]          ctl_q;
    wire [31:0]          tmr_q;
    wire [31:0]          f0_q;
    wire [31:0]          f1_q;
    wire [31:0]          e0_q;
    wire [31:0]          e1_q;
    wire [31:0]          evm_q;
    wire [NSLOT*8-1:0]   prio_flat;

    wire [NEXT-1:0] pol = ctl_q[`CTL_POL_LSB +: NEXT];
    wire [2:0]      timer_priority_threshold = ctl_q[`CTL_TPC_LSB +: 3];
    wire            multi_vector_select = ctl_q[`CTL_MULTI_VECTOR_SELECT_BIT];

    // external edge detection, polarity 1 = rising
    reg  [NEXT-1:0] ext_q;
    wire [NEXT-1:0] ext_edge = (ext_in & ~ext_q & pol) |
                               (~ext_in & ext_q & ~pol);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ext_q <= {NEXT{1'b0}};
        end else begin
            ext_q <= ext_in;
        end
    end

    // hardware flag sets; set wins over a simultaneous clear
    reg [63:0] hw_set;
    always @* begin
        hw_set = 64'h0;
        hw_set[NSRC-1:0] = periph_req;
        hw_set[`EXT0_BIT] = hw_set[`EXT0_BIT] | ext_edge[0];
        hw_set[`EXT1_BIT] = hw_set[`EXT1_BIT] | ext_edge[1];
        hw_set[`EXT2_BIT] = hw_set[`EXT2_BIT] | ext_edge[2];
        hw_set[`EXT3_BIT] = hw_set[`EXT3_BIT] | ext_edge[3];
        hw_set[`EXT4_BIT] = hw_set[`EXT4_BIT] | ext_edge[4];
    end

    alias_reg #(.WIDTH(32), .IMPL(`CTL_IMPL)) u_ctl (
        .clk(clk), .resetn(resetn), .wr_en(bus_wr & hit_ctl), .op(op),
        .wdata(pwdata), .hw_set(`ALL_ZERO), .q(ctl_q));
    alias_reg #(.WIDTH(32), .IMPL(`ALL_ONES)) u_tmr (
        .clk(clk), .resetn(resetn), .wr_en(bus_wr & hit_tmr), .op(op),
        .wdata(pwdata), .hw_set(`ALL_ZERO), .q(tmr_q));
    alias_reg #(.WIDTH(32), .IMPL(`ALL_ONES)) u_f0 (
        .clk(clk), .resetn(resetn), .wr_en(bus_wr & hit_f0), .op(op),
        .wdata(pwdata), .hw_set(hw_set[31:0]), .q(f0_q));
    alias_reg #(.WIDTH(32), .IMPL(USB_MASK)) u_f1 (
        .clk(clk), .resetn(resetn), .wr_en(bus_wr & hit_f1), .op(op),
        .wdata(pwdata), .hw_set(hw_set[63:32]), .q(f1_q));
    alias_reg #(.WIDTH(32), .IMPL(`ALL_ONES)) u_e0 (
        .clk(clk), .resetn(resetn), .wr_en(bus_wr & hit_e0), .op(op),
        .wdata(pwdata), .hw_set(`ALL_ZERO), .q(e0_q));
    alias_reg #(.WIDTH(32), .IMPL(USB_MASK)) u_e1 (
        .clk(clk), .resetn(resetn), .wr_en(bus_wr & hit_e1), .op(op),
        .wdata(pwdata), .hw_set(`ALL_ZERO), .q(e1_q));

    genvar g;
    generate
        for (g = 0; g < `NUM_PRIO_GROUPS; g = g + 1) begin : gen_prio
            alias_reg #(.WIDTH(32), .IMPL(`PRIO_IMPL)) u_prio (
                .clk(clk), .resetn(resetn),
                .wr_en(bus_wr & hit_prio & (prio_idx == g)), .op(op),
                .wdata(pwdata), .hw_set(`ALL_ZERO), .q(prio_flat[g*32 +: 32]));
        end
    endgenerate

    // enable gates the flag at the same bit position
    wire [63:0] pending = {f1_q & e1_q, f0_q & e0_q};

    wire       win_valid;
    wire [2:0] win_level;
    wire [5:0] win_vector;

    priority_pick #(.NSRC(NSRC), .NSLOT(NSLOT)) u_pick (
        .pending(pending[NSRC-1:0]),
        .slots(prio_flat),
        .valid(win_valid),
        .level(win_level),
        .vector(win_vector));

    // latency window: low-level requests wait for the timer before reaching the core
    reg  [31:0] win_cnt_q;
    wire        defer = win_valid && (timer_priority_threshold != 3'h0) && (win_level <= timer_priority_threshold);

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            win_cnt_q   <= `ALL_ZERO;
            cpu_request <= 1'b0;
            cpu_level   <= 3'h0;
            cpu_vector  <= 6'h00;
        end else begin
            if (!defer) begin
                win_cnt_q <= tmr_q;
            end else if (win_cnt_q != `ALL_ZERO) begin
                win_cnt_q <= win_cnt_q - 32'h1;
            end
            cpu_request <= win_valid & (~defer | (win_cnt_q == `ALL_ZERO));
            cpu_level   <= win_valid ? win_level : 3'h0;
            // single-vector mode always presents vector zero
            cpu_vector  <= (win_valid & multi_vector_select) ? win_vector : 6'h00;
        end
    end

    wire [31:0] stat_word = {21'h0, cpu_level, 2'h0, cpu_vector};

    // block event status: sticky, write one to clear, set wins
    reg  [31:0] evs_q;
    wire [31:0] evs_set = {30'h0, pslverr, |hw_set[NSRC-1:0]};
    wire [31:0] evs_clr = (bus_wr & hit_evs & (op == `OP_WRITE)) ? pwdata : `ALL_ZERO;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            evs_q <= `ALL_ZERO;
        end else begin
            evs_q <= ((evs_q & ~evs_clr) | evs_set) & `EVT_IMPL;
        end
    end

    alias_reg #(.WIDTH(32), .IMPL(`EVT_IMPL)) u_evm (
        .clk(clk), .resetn(resetn), .wr_en(bus_wr & hit_evm), .op(op),
        .wdata(pwdata), .hw_set(`ALL_ZERO), .q(evm_q));

    assign irq = |(evs_q & evm_q);

    // read mux; companions read zero
    wire [31:0] prio_word = prio_flat[prio_idx[2:0]*32 +: 32];
    reg  [31:0] rd_d;
    always @* begin
        rd_d = `ALL_ZERO;
        if (op == `OP_WRITE) begin
            if (hit_ctl)  rd_d = ctl_q;
            if (hit_stat) rd_d = stat_word;
            if (hit_tmr)  rd_d = tmr_q;
            if (hit_f0)   rd_d = f0_q;
            if (hit_f1)   rd_d = f1_q;
            if (hit_e0)   rd_d = e0_q;
            if (hit_e1)   rd_d = e1_q;
            if (hit_prio) rd_d = prio_word;
            if (hit_evs)  rd_d = evs_q;
            if (hit_evm)  rd_d = evm_q;
        end
    end

    always @* begin
        prdata = (bus_acc & ~pwrite) ? rd_d : `ALL_ZERO;
    end

endmodule // irq_ctrl

// File: verif/irq_ctrl_monitor.sv
// port checker of the interrupt register bank
// bound to irq_ctrl; sees only its ports, one clock domain
`timescale 1ns/1ps
module irq_ctrl_monitor #(
    parameter HAS_USB = 1
) (
    input wire        clk,         // system clock
    input wire        resetn,      // async reset, active low
    input wire        psel,        // apb select
    input wire        penable,     // apb access phase
    input wire        pwrite,      // apb direction
    input wire [15:0] paddr,       // apb address
    input wire [31:0] pwdata,      // apb write data
    input wire        pready,      // apb ready
    input wire [31:0] prdata,      // apb read data
    input wire        pslverr,     // apb error
    input wire        cpu_request, // request to core
    input wire [2:0]  cpu_level,   // requested level
    input wire [5:0]  cpu_vector,  // vector
    input wire        irq          // event interrupt
);
    wire acc = psel && penable;
    wire rd  = acc && !pwrite;

    // control word as software expects it after plain and companion writes
    logic [31:0] ctl_exp_q;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_exp_q <= 32'h00000000;
        end else if (acc && pwrite && paddr[15:4] == 12'h100) begin
            case (paddr[3:2])
                2'h0:    ctl_exp_q <= pwdata;
                2'h1:    ctl_exp_q <= ctl_exp_q & ~pwdata;
                2'h2:    ctl_exp_q <= ctl_exp_q | pwdata;
                default: ctl_exp_q <= ctl_exp_q ^ pwdata;
            endcase
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (!resetn);

    one_cycle_access_a: assert property (psel && !penable |=> pready)
        else $error("access phase not ready");
    alias_read_zero_a: assert property (rd && paddr[15:8] == 8'h10 && paddr[3:2] != 2'h0
        |-> prdata == 32'h0) else $error("companion read not zero");
    alias_mapped_a: assert property (acc && paddr inside {16'h1004, 16'h1008, 16'h100C}
        |-> !pslverr) else $error("companion address refused");
    status_alias_err_a: assert property (acc && paddr inside {16'h1014, 16'h1018, 16'h101C}
        |-> pslverr) else $error("status companion decoded");
    ctl_reserved_a: assert property (rd && paddr == 16'h1000
        |-> (prdata & ~32'h0000171F) == 32'h0) else $error("control reserved bits set");
    status_fields_a: assert property (rd && paddr == 16'h1010
        |-> prdata == {21'h0, cpu_level, 2'h0, cpu_vector}) else $error("status layout");
    prio_reserved_a: assert property (rd && paddr >= 16'h1090 && paddr <= 16'h10F0
        && paddr[3:0] == 4'h0 |-> (prdata & 32'hE0E0E0E0) == 32'h0) else $error("slot top bits");
    usb_absent_a: assert property (rd && HAS_USB == 0 && paddr inside {16'h1040, 16'h1070}
        |-> !prdata[3]) else $error("usb bit present");
    ctl_alias_model_a: assert property (rd && paddr == 16'h1000
        |-> prdata == (ctl_exp_q & 32'h0000171F)) else $error("control companion write");
    reset_quiet_a: assert property ($rose(resetn) |-> !cpu_request && !irq
        && cpu_level == 3'h0 && cpu_vector == 6'h0) else $error("outputs not zero after reset");
endmodule // irq_ctrl_monitor

bind irq_ctrl irq_ctrl_monitor #(.HAS_USB(HAS_USB)) u_mon (.clk(clk), .resetn(resetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cpu_request(cpu_request), .cpu_level(cpu_level),
    .cpu_vector(cpu_vector), .irq(irq));

// File: verif/irq_source_model.sv
// far side: peripheral request lines and external interrupt pins
// driven through its tasks; changes only right after a rising edge
`timescale 1ns/1ps
module irq_source_model (
    input  wire         clk,        // system clock
    input  wire         resetn,     // async reset, active low
    output logic [63:0] periph_req, // request pulses
    output logic [4:0]  ext_in      // external pins
);
    initial begin
        periph_req = 64'h0;
        ext_in = 5'h0;
    end
    // one-cycle pulse: a peripheral never holds its request line
    task pulse(input integer k);
        begin
            @(posedge clk);
            periph_req[k] <= 1'b1;
            @(posedge clk);
            periph_req[k] <= 1'b0;
        end
    endtask
    task ext(input integer k, input logic v);
        begin
            @(posedge clk);
            ext_in[k] <= v;
        end
    endtask
endmodule // irq_source_model

// File: verif/tb_top.sv
// self-checking bench of the interrupt register bank over apb
// design built without usb; sources come from irq_source_model
`timescale 1ns/1ps
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin n_errors++; \
    $display("[FAIL] %s expected %h seen %h", n, x, g); end end
module tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] r;
    logic        e;
    wire         pready, pslverr, cpu_request, irq;
    wire  [31:0] prdata;
    wire  [2:0]  cpu_level;
    wire  [5:0]  cpu_vector;
    wire  [63:0] periph_req;
    wire  [4:0]  ext_in;
    integer      n_errors = 0;
    integer      compares = 0;
    integer      i;

    always #20 clk = ~clk;

    irq_ctrl #(.HAS_USB(0)) i_irq_ctrl (.clk(clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .periph_req(periph_req),
        .ext_in(ext_in), .cpu_request(cpu_request), .cpu_level(cpu_level),
        .cpu_vector(cpu_vector), .irq(irq));
    irq_source_model u_src (.clk(clk), .resetn(resetn), .periph_req(periph_req),
        .ext_in(ext_in));

    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            // no local limit: only the watchdog ends a stuck access
            do begin
                @(posedge clk);
            end while (pready !== 1'b1);
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task wr(input logic [15:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [15:0] a, input logic [31:0] x);
        begin
            apb(1'b0, a, 32'h00000000);
            `CHK($sformatf("read %h", a), x, r)
        end
    endtask
    // bounded wait: the request follows flag changes within a few edges
    task waitreq(input logic v);
        integer n;
        begin
            n = 0;
            while (cpu_request !== v && n < 10) begin
                @(posedge clk);
                n = n + 1;
            end
            `CHK("cpu_request", v, cpu_request)
        end
    endtask
    task results;
        begin
            if (n_errors == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        n_errors = n_errors + 1;
        results;
    end

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        // top down: event status is read before an unmapped slot latches a bus error
        for (i = 17; i >= 0; i--) rdc(16'(16'h1000 + 16 * i), 32'h00000000);
        wr(16'h1000, 32'hFFFFFFFF);
        rdc(16'h1000, 32'h0000171F);
        wr(16'h1004, 32'h00000003);
        rdc(16'h1000, 32'h0000171C);
        wr(16'h1008, 32'h00000001);
        rdc(16'h1000, 32'h0000171D);
        wr(16'h100C, 32'h00001000);
        rdc(16'h1000, 32'h0000071D);
        rdc(16'h1004, 32'h00000000);
        wr(16'h1000, 32'h00001000);
        wr(16'h1020, 32'hA5A55AF0);
        wr(16'h1024, 32'hFFFF0000);
        rdc(16'h1020, 32'h00005AF0);
        wr(16'h102C, 32'h0000FFFF);
        rdc(16'h1020, 32'h0000A50F);
        for (i = 0; i < 7; i++) begin
            wr(16'(16'h1090 + 16 * i), 32'hFFFFFFFF);
            rdc(16'(16'h1090 + 16 * i), 32'h1F1F1F1F);
            wr(16'(16'h1094 + 16 * i), 32'hFFFFFFFF);
            rdc(16'(16'h1090 + 16 * i), 32'h00000000);
        end
        wr(16'h1040, 32'hFFFFFFFF);
        rdc(16'h1040, 32'hFFFFFFF7);
        wr(16'h1044, 32'hFFFFFFFF);
        wr(16'h1070, 32'hFFFFFFFF);
        rdc(16'h1070, 32'hFFFFFFF7);
        wr(16'h1074, 32'hFFFFFFFF);
        wr(16'h1090, 32'h00001C00);
        wr(16'h1068, 32'h00000002);
        wr(16'h1110, 32'h00000001);
        u_src.pulse(1);
        u_src.pulse(0);
        waitreq(1'b1);
        `CHK("cpu_level", 3'h7, cpu_level)
        `CHK("cpu_vector", 6'h01, cpu_vector)
        wr(16'h1010, 32'hFFFFFFFF);
        rdc(16'h1010, 32'h00000701);
        apb(1'b0, 16'h1014, 32'h00000000);
        `CHK("status companion error", 1'b1, e)
        wr(16'h1004, 32'h00001000);
        rdc(16'h1010, 32'h00000700);
        rdc(16'h1030, 32'h00000003);
        @(negedge clk);
        `CHK("irq", 1'b1, irq)
        wr(16'h1114, 32'h00000001);
        @(negedge clk);
        `CHK("irq", 1'b0, irq)
        wr(16'h1118, 32'h00000001);
        @(negedge clk);
        `CHK("irq", 1'b1, irq)
        wr(16'h1100, 32'h00000003);
        @(negedge clk);
        `CHK("irq", 1'b0, irq)
        wr(16'h1034, 32'h00000001);
        rdc(16'h1030, 32'h00000002);
        wr(16'h1034, 32'h00000002);
        waitreq(1'b0);
        wr(16'h1008, 32'h00000001);
        u_src.ext(0, 1'b1);
        repeat (3) @(posedge clk);
        rdc(16'h1030, 32'h00000008);
        // input 1 still selects the falling edge
        u_src.ext(1, 1'b1);
        u_src.ext(1, 1'b0);
        repeat (2) @(posedge clk);
        rdc(16'h1030, 32'h00000108);
        apb(1'b0, 16'h2000, 32'h00000000);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 32'h00000000, r)
        // reset again with flags and timer non-zero
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdc(16'h1030, 32'h00000000);
        rdc(16'h1020, 32'h00000000);
        results;
    end
endmodule // tb_top
